// ---- rtl/acs_sequencer.v ----
// Conversion cycle sequencer with serial output and configuration input
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_sequencer #(
  parameter POR_CYCLES = `ACS_POR_CYCLES,
  parameter CONV_TICKS = `ACS_CONV_TICKS,
  parameter CAL_TICKS = `ACS_CAL_TICKS,
  parameter INT_OSC_DIV = `ACS_INT_OSC_DIV,
  parameter ISCK_DIV = `ACS_ISCK_DIV,
  parameter CFG_BITS = `ACS_CFG_BITS
) (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Supply monitor
  input wire supplyLowPin,
  // Serial link
  input wire selectNPin,
  input wire sckPin,
  output reg sckOut,
  output reg sckOutEnN,
  input wire serialInPin,
  output reg serialOutPin,
  output reg serialOutEnN,
  // Conversion clock
  input wire convClkPin,
  input wire useExtConvClk,
  // Front end result
  input wire measSign,
  input wire [`ACS_RES_BITS-1:0] measBits,
  input wire measOver,
  input wire measUnder,
  // Front end control and status
  output reg [CFG_BITS-1:0] cfgActive,
  output reg convBusy,
  output reg [1:0] calPhase,
  output reg convDone,
  output reg internalClear,
  output reg sckExternal,
  output reg [1:0] seqState
);

  wire [4:0] syncIn;
  wire supplyLowS;
  wire selectNS;
  wire sckS;
  wire sdiS;
  wire convClkS;

  reg [23:0] porCnt;
  reg [1:0] state;
  reg prevSelectN;
  reg prevConvClk;
  reg [15:0] oscCnt;
  reg [15:0] convCnt;
  reg [`ACS_WORD_BITS-1:0] resultWord;
  reg [`ACS_WORD_BITS-1:0] outShift;
  reg [4:0] bitCount;
  reg [CFG_BITS-1:0] cfgShift;
  reg [15:0] genCnt;
  reg genSck;
  reg prevSck;
  reg extConvSel;

  wire effSck;
  wire sckRise;
  wire sckFall;
  wire selectFall;
  wire convTick;
  wire inData;
  wire lastTick;
  wire cfgFull;
  reg [`ACS_WORD_BITS-1:0] next_word;
  reg [1:0] next_state;
  reg next_sdo;
  reg next_sdoEnN;

  // Every pin is two flops away from the logic that reads it
  acs_sync #(
    .WIDTH(5)
  ) pinSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn({supplyLowPin, selectNPin, sckPin, serialInPin, convClkPin}),
    .syncOut(syncIn)
  );

  assign supplyLowS = syncIn[4];
  assign selectNS = syncIn[3];
  assign sckS = syncIn[2];
  assign sdiS = syncIn[1];
  assign convClkS = syncIn[0];

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      porCnt <= 24'h000000;
      internalClear <= 1'b1;
    end
    else if (supplyLowS)
    begin
      porCnt <= 24'h000000;
      internalClear <= 1'b1;
    end
    else if (porCnt < POR_CYCLES[23:0] - 24'h000001)
    begin
      porCnt <= porCnt + 24'h000001;
      internalClear <= 1'b1;
    end
    else
    begin
      internalClear <= 1'b0;
    end
  end

  // Conversion clock: internal divider or rising edges of the external pin
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oscCnt <= 16'h0000;
      prevConvClk <= 1'b0;
      extConvSel <= 1'b0;
    end
    else
    begin
      prevConvClk <= convClkS;
      extConvSel <= useExtConvClk;
      if (oscCnt >= INT_OSC_DIV[15:0] - 16'h0001)
        oscCnt <= 16'h0000;
      else
        oscCnt <= oscCnt + 16'h0001;
    end
  end

  assign convTick = extConvSel ? (convClkS & ~prevConvClk) : (oscCnt == 16'h0000);
  assign lastTick = convTick && (convCnt >= CONV_TICKS[15:0] - 16'h0001);

  // clamped codes mark over and underrange
  always @*
  begin
    next_word = {`ACS_WORD_BITS{1'b0}};
    if (measOver)
    begin
      next_word[`ACS_BIT_SIGN] = 1'b1;
      next_word[`ACS_RES_MSB:`ACS_RES_LSB] = `ACS_RES_OVER;
    end
    else if (measUnder)
    begin
      next_word[`ACS_BIT_SIGN] = 1'b0;
      next_word[`ACS_RES_MSB:`ACS_RES_LSB] = `ACS_RES_UNDER;
    end
    else
    begin
      next_word[`ACS_BIT_SIGN] = measSign;
      next_word[`ACS_RES_MSB:`ACS_RES_LSB] = measBits;
    end
  end

  // Serial clock: the internal generator runs only while a transfer is open
  assign inData = (state == `ACS_ST_DATA);
  assign effSck = sckExternal ? sckS : genSck;
  assign sckRise = inData && !selectNS && effSck && !prevSck;
  assign sckFall = inData && !selectNS && !effSck && prevSck;
  assign selectFall = !selectNS && prevSelectN;
  assign cfgFull = (bitCount >= CFG_BITS[4:0]);

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      genCnt <= 16'h0000;
      genSck <= 1'b0;
      prevSck <= 1'b0;
      prevSelectN <= 1'b1;
      sckExternal <= 1'b0;
    end
    else if (internalClear)
    begin
      genCnt <= 16'h0000;
      genSck <= 1'b0;
      prevSck <= 1'b0;
      prevSelectN <= 1'b1;
      sckExternal <= !sckS;
    end
    else
    begin
      prevSck <= effSck;
      prevSelectN <= selectNS;
      if (selectFall)
        sckExternal <= !sckS;
      if (inData && !selectNS && !sckExternal)
      begin
        if (genCnt >= ISCK_DIV[15:0] - 16'h0001)
        begin
          genCnt <= 16'h0000;
          genSck <= !genSck;
        end
        else
          genCnt <= genCnt + 16'h0001;
      end
      else
      begin
        genCnt <= 16'h0000;
        genSck <= 1'b0;
      end
    end
  end

  // modes need no setting, one cycle order
  always @*
  begin
    next_state = state;
    case (state)
      `ACS_ST_CONV:
      begin
        if (lastTick)
          next_state = `ACS_ST_SLEEP;
      end
      `ACS_ST_SLEEP:
      begin
        if (!selectNS)
          next_state = `ACS_ST_DATA;
      end
      `ACS_ST_DATA:
      begin
        if (selectNS && bitCount == 5'h00)
          next_state = `ACS_ST_SLEEP;
        else if (selectNS)
          next_state = `ACS_ST_CONV;
        else if (sckFall && bitCount == `ACS_WORD_BITS)
          next_state = `ACS_ST_CONV;
      end
      default:
        next_state = `ACS_ST_CONV;
    endcase
  end

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= `ACS_ST_CONV;
      convCnt <= 16'h0000;
      convDone <= 1'b0;
      resultWord <= {`ACS_WORD_BITS{1'b0}};
      outShift <= {`ACS_WORD_BITS{1'b0}};
      bitCount <= 5'h00;
      cfgShift <= `ACS_CFG_DEFAULT;
      cfgActive <= `ACS_CFG_DEFAULT;
    end
    else if (internalClear)
    begin
      state <= `ACS_ST_CONV;
      convCnt <= 16'h0000;
      convDone <= 1'b0;
      resultWord <= {`ACS_WORD_BITS{1'b0}};
      outShift <= {`ACS_WORD_BITS{1'b0}};
      bitCount <= 5'h00;
      cfgShift <= `ACS_CFG_DEFAULT;
      cfgActive <= `ACS_CFG_DEFAULT;
    end
    else
    begin
      state <= next_state;
      convDone <= 1'b0;
      case (state)
        `ACS_ST_CONV:
        begin
          if (lastTick)
          begin
            convCnt <= 16'h0000;
            convDone <= 1'b1;
            resultWord <= next_word;
            outShift <= next_word;
          end
          else if (convTick)
            convCnt <= convCnt + 16'h0001;
          bitCount <= 5'h00;
        end
        `ACS_ST_SLEEP:
        begin
          convCnt <= 16'h0000;
          bitCount <= 5'h00;
        end
        `ACS_ST_DATA:
        begin
          if (next_state == `ACS_ST_SLEEP)
          begin
            outShift <= resultWord;
            bitCount <= 5'h00;
          end
          else if (next_state == `ACS_ST_CONV)
          begin
            if (cfgFull)
              cfgActive <= cfgShift;
            bitCount <= 5'h00;
          end
          else
          begin
            if (sckRise)
            begin
              if (!cfgFull)
                cfgShift <= {cfgShift[CFG_BITS-2:0], sdiS};
              bitCount <= bitCount + 5'h01;
            end
            if (sckFall)
              outShift <= {outShift[`ACS_WORD_BITS-2:0], 1'b0};
          end
        end
        default:
          bitCount <= 5'h00;
      endcase
    end
  end

  // data bits or busy flag while selected, tri-state otherwise
  always @*
  begin
    next_sdoEnN = 1'b1;
    next_sdo = 1'b0;
    if (!selectNS)
    begin
      next_sdoEnN = 1'b0;
      if (state == `ACS_ST_DATA && next_state == `ACS_ST_DATA)
        next_sdo = outShift[`ACS_WORD_BITS-1];
      // high once the new conversion begins
      else if (state == `ACS_ST_CONV || next_state == `ACS_ST_CONV)
        next_sdo = 1'b1;
      else
        next_sdo = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serialOutPin <= 1'b0;
      serialOutEnN <= 1'b1;
      sckOut <= 1'b0;
      sckOutEnN <= 1'b1;
      convBusy <= 1'b0;
      calPhase <= `ACS_CAL_OFFSET;
      seqState <= `ACS_ST_CONV;
    end
    else if (internalClear)
    begin
      serialOutPin <= 1'b0;
      serialOutEnN <= 1'b1;
      sckOut <= 1'b0;
      sckOutEnN <= 1'b1;
      convBusy <= 1'b0;
      calPhase <= `ACS_CAL_OFFSET;
      seqState <= `ACS_ST_CONV;
    end
    else
    begin
      serialOutPin <= next_sdo;
      serialOutEnN <= next_sdoEnN;
      sckOut <= genSck;
      sckOutEnN <= !(inData && !selectNS && !sckExternal);
      convBusy <= (state == `ACS_ST_CONV);
      seqState <= state;
      if (state != `ACS_ST_CONV)
        calPhase <= `ACS_CAL_OFFSET;
      else if (convCnt < CAL_TICKS[15:0])
        calPhase <= `ACS_CAL_OFFSET;
      else if (convCnt < {CAL_TICKS[14:0], 1'b0})
        calPhase <= `ACS_CAL_FULL;
      else
        calPhase <= `ACS_CAL_SAMPLE;
    end
  end

endmodule // acs_sequencer

// ---- rtl/acs_map.vh ----
// Constants for the conversion cycle sequencer
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// Timing
`define ACS_CLK_HZ 25000000
`define ACS_POR_TIME_US 4000
`define ACS_POR_CYCLES (`ACS_POR_TIME_US * (`ACS_CLK_HZ / 1000000))
`define ACS_CONV_TICKS 64
`define ACS_CAL_TICKS 16
`define ACS_INT_OSC_DIV 82
`define ACS_ISCK_DIV 4

// Output word layout
`define ACS_WORD_BITS 24
`define ACS_BIT_EOC 23
`define ACS_BIT_DUMMY 22
`define ACS_BIT_SIGN 21
`define ACS_RES_MSB 20
`define ACS_RES_LSB 4
`define ACS_RES_BITS 17
`define ACS_RES_OVER 17'h10000
`define ACS_RES_UNDER 17'h0FFFF

// Configuration: input_zero positive, input_one negative, 50/60 rejection, 1x, gain 1
`define ACS_CFG_BITS 16
`define ACS_CFG_DEFAULT 16'h0000

// Sequencer states
`define ACS_ST_CONV 2'h0
`define ACS_ST_SLEEP 2'h1
`define ACS_ST_DATA 2'h2

// Calibration phases
`define ACS_CAL_OFFSET 2'h0
`define ACS_CAL_FULL 2'h1
`define ACS_CAL_SAMPLE 2'h2

`endif

// ---- rtl/acs_sync.v ----
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
module acs_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Pins
  input wire [WIDTH-1:0] pinIn,
  // Synchronised levels
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= pinIn;
      syncOut <= stage1;
    end
  end

endmodule // acs_sync

// ---- sim/acs_sequencer_asserts.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
module acs_sequencer_asserts (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Link and status
  input wire supplyLowPin,
  input wire selectNPin,
  input wire serialOutPin,
  input wire serialOutEnN,
  input wire convBusy,
  input wire [1:0] calPhase,
  input wire convDone,
  input wire internalClear,
  input wire [1:0] seqState
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  a_deselect_tristate: assert property (selectNPin [*5] |-> serialOutEnN)
    else $error("output driven while deselected");
  a_busy_high: assert property (convBusy && $past(convBusy) && !serialOutEnN && !selectNPin |-> serialOutPin)
    else $error("busy flag not high");
  a_supply_clears: assert property (supplyLowPin [*4] |-> internalClear)
    else $error("no clear while supply low");
  a_clear_idle: assert property (internalClear && $past(internalClear) |-> !convBusy && seqState == 2'h0)
    else $error("activity during clear");
  a_first_conv: assert property ($fell(internalClear) |-> ##[0:2] convBusy)
    else $error("no conversion after clear");
  a_done_pulse: assert property (convDone |=> !convDone)
    else $error("done pulse too long");
  a_done_sleeps: assert property (convDone |-> ##[0:2] (seqState == 2'h1 && !convBusy))
    else $error("no sleep after done");
  a_conv_bounded: assert property ($rose(convBusy) |-> ##[1:200] convDone)
    else $error("conversion never ends");
  a_cal_steps: assert property (convBusy && $past(convBusy) && calPhase != $past(calPhase)
    |-> calPhase == $past(calPhase) + 2'h1)
    else $error("calibration phase skipped");
endmodule // acs_sequencer_asserts
bind acs_sequencer acs_sequencer_asserts i_chk (.sys_clk, .resetn, .supplyLowPin, .selectNPin, .serialOutPin,
  .serialOutEnN, .convBusy, .calPhase, .convDone, .internalClear, .seqState);

// ---- sim/acs_host_model.sv ----
// Host side of the serial link: select, clock and configuration bits
`timescale 1ns/100ps
module acs_host_model (
  // Timing reference
  input wire clk,
  // Link
  output reg selectN,
  output reg sck,
  output reg serial_in_pin,
  input wire serial_out_pin
);
  initial
  begin
    selectN = 1'b1;
    sck = 1'b0;
    serial_in_pin = 1'b1;
  end
  // Leaves select low so the caller can watch the output afterwards
  task xfer(input integer nBits, input integer extClk, input [15:0] cfg, output [23:0] word);
    integer i;
    begin
      word = 24'h000000;
      @(posedge clk) #2;
      sck = (extClk == 0);
      #400 selectN = 1'b0;
      #400;
      for (i = 0; i < nBits; i = i + 1)
      begin
        serial_in_pin = (i < 16) ? cfg[15 - i] : ~serial_in_pin;
        #160 word[23 - i] = serial_out_pin;
        sck = 1'b1;
        #160 sck = 1'b0;
      end
    end
  endtask
  task finish_xfer;
    begin
      @(posedge clk) #2;
      selectN = 1'b1;
      sck = 1'b0;
      serial_in_pin = ~serial_in_pin;
      #400;
    end
  endtask
endmodule // acs_host_model

// ---- sim/acs_sequencer_tb_top.sv ----
// Self-checking bench for the conversion cycle sequencer
`timescale 1ns/100ps
module acs_sequencer_tb_top;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg supplyLowPin = 1'b0;
  reg convClkPin = 1'b0;
  reg useExtConvClk = 1'b0;
  reg measSign = 1'b1;
  reg [16:0] measBits = 17'h0A5C3;
  reg measOver = 1'b0;
  reg measUnder = 1'b0;
  wire selectN, hostSck, serial_in_pin, sckOut, sckOutEnN, serialOutPin, serialOutEnN;
  wire convBusy, convDone, internalClear, sckExternal;
  wire [15:0] cfgActive;
  wire [1:0] calPhase, seqState;
  wire sckLine = sckOutEnN ? hostSck : sckOut;
  wire sdoLine = serialOutEnN ? 1'bz : serialOutPin;
  integer bad_count = 0;
  integer n_tests = 0;
  reg [23:0] word;
  always #20 sys_clk = ~sys_clk;
  // Pin moves just after an edge, like every other stimulus
  always
  begin
    repeat (3) @(posedge sys_clk);
    #2 convClkPin = ~convClkPin;
  end
  acs_host_model i_host (.clk(sys_clk), .selectN(selectN), .sck(hostSck), .serial_in_pin(serial_in_pin), .serial_out_pin(sdoLine));
  acs_sequencer #(.POR_CYCLES(20), .CONV_TICKS(8), .CAL_TICKS(2), .INT_OSC_DIV(2)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .supplyLowPin(supplyLowPin), .selectNPin(selectN),
    .sckPin(sckLine), .sckOut(sckOut), .sckOutEnN(sckOutEnN), .serialInPin(serial_in_pin),
    .serialOutPin(serialOutPin), .serialOutEnN(serialOutEnN), .convClkPin(convClkPin),
    .useExtConvClk(useExtConvClk), .measSign(measSign), .measBits(measBits), .measOver(measOver),
    .measUnder(measUnder), .cfgActive(cfgActive), .convBusy(convBusy), .calPhase(calPhase),
    .convDone(convDone), .internalClear(internalClear), .sckExternal(sckExternal), .seqState(seqState));
  task check(input [23:0] got, input [23:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Bounded so a stuck sequencer cannot hang the run
  task wait_sleep;
    integer k;
    begin
      k = 0;
      while (seqState !== 2'h1 && k < 600)
      begin
        @(posedge sys_clk) #2;
        k = k + 1;
      end
      check({22'h0, seqState}, 24'h000001);
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    #500000;
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #2 resetn = 1'b1;
    wait_sleep;
    check({8'h0, cfgActive}, 24'h000000);
    i_host.xfer(0, 1, 16'h0000, word);
    i_host.finish_xfer;
    check({21'h0, convBusy, seqState}, 24'h000001);
    $display("test wake without clock done");
    measOver = 1'b1;
    i_host.xfer(24, 1, 16'h5A3C, word);
    check(word, {3'b001, 17'h0A5C3, 4'h0});
    #200 check({23'h0, sdoLine}, 24'h000001);
    wait_sleep;
    check({8'h0, cfgActive}, 24'h005A3C);
    check({23'h0, sdoLine}, 24'h000000);
    i_host.finish_xfer;
    $display("test full word done");
    {measOver, measUnder, measSign} = 3'b010;
    i_host.xfer(24, 1, 16'h1234, word);
    check(word, {3'b001, 17'h10000, 4'h0});
    wait_sleep;
    i_host.finish_xfer;
    i_host.xfer(5, 1, 16'hFFFF, word);
    i_host.finish_xfer;
    check(word, 24'h080000);
    check({23'h0, convBusy}, 24'h000001);
    wait_sleep;
    check({8'h0, cfgActive}, 24'h001234);
    $display("test range codes and abort done");
    supplyLowPin = 1'b1;
    repeat (6) @(posedge sys_clk);
    #2 supplyLowPin = 1'b0;
    wait_sleep;
    check({8'h0, cfgActive}, 24'h000000);
    $display("test supply dip done");
    i_host.xfer(0, 0, 16'h0000, word);
    repeat (20) @(posedge sys_clk);
    #2 check({21'h0, sckExternal, seqState}, 24'h000002);
    check({23'h0, sckOutEnN}, 24'h000000);
    wait_sleep;
    i_host.finish_xfer;
    $display("test internal clock done");
    useExtConvClk = 1'b1;
    wait_sleep;
    i_host.xfer(24, 1, 16'hC3A5, word);
    check(word, {3'b000, 17'h0FFFF, 4'h0});
    // Internal divider would be done in about 16 cycles; external ticks need about 50
    repeat (30) @(posedge sys_clk);
    #2 check({23'h0, convBusy}, 24'h000001);
    wait_sleep;
    check({8'h0, cfgActive}, 24'h00C3A5);
    i_host.finish_xfer;
    $display("test external conversion clock done");
    print_verdict;
  end
endmodule // acs_sequencer_tb_top
